// file: core/css_serial_channel.sv
// top: clock-synchronous serial channel with register port and interrupt
// Notes on behaviour
// RULE1: external clock with flow control: request low when ready, high once reception begins.
// RULE2: with internal shift clock the request-to-send output has no effect.
// RULE3: partner waits for idle clock, enable, buffer load, then lowers clear-to-send.
// RULE4: only the transmitter makes the clock; dummy bits leave while receiving.
// RULE5: internal clock starts once transmit enabled and transmit buffer written.
// RULE6: external clock shifts only after enable and buffer load, partner clocks.
// RULE7: word completing while receive-full is set sets overrun and still overwrites buffer.
// RULE8: on overrun the receive interrupt bit stays unchanged.
// RULE9: software writes a dummy low byte per word for continuous reception.
// RULE10: receive set-up order: receive enable, transmit enable, dummy write.
// RULE11: request-to-send goes low as soon as receive enable is set.
// RULE12: request-to-send returns low when a word has been fully received.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module css_serial_channel (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // shift clock pin, two-way
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe_n,
  // data pins and flow control
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  input wire logic cts_n,
  output logic rts_n,
  // interrupt
  output logic irq
);
  import css_pkg::*;

  // ****************************************
  // pin synchronisation
  // ****************************************
  css_pin_if pins ();
  css_sync u_sync (
    .clk(clk),
    .reset(reset),
    .shift_clock_in(shift_clock_pin_i),
    .cts_n_in(cts_n),
    .rx_in(serial_in_pin),
    .p(pins.sync)
  );

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] div;
    logic [7:0] txbuf;
    logic txempty;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic [7:0] rxbuf;
    logic rxfull;
    logic ovr;
    logic [2:0] irqst;
    logic [2:0] mask;
    logic [2:0] bitcnt;
    logic [7:0] divcnt;
    css_st_e st;
    logic sclk;
    logic txd;
    logic rts_n;
    logic [7:0] rdata;
  } css_s;
  css_s q_r, q_nxt;

  function automatic logic [2:0] w1c(input logic [2:0] cur, input logic [2:0] set, input logic [2:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction : w1c

  logic te, re, intclk, pol, rtsen, ctsen;
  logic sample_edge, ctsok;
  logic [2:0] ev, clr;
  logic done;

  always_comb begin
    te = q_r.ctrl[CSS_C_TE];
    re = q_r.ctrl[CSS_C_RE];
    intclk = q_r.ctrl[CSS_C_INTCLK];
    pol = q_r.ctrl[CSS_C_POL];
    rtsen = q_r.ctrl[CSS_C_RTS];
    ctsen = q_r.ctrl[CSS_C_CTS];
    ctsok = ~ctsen | ~pins.cts_n_lvl;
    // rising edge (pol 0) samples; with an outside clock the next bit follows the sample,
    // since the synchroniser delay nearly fills a half period of the partner's clock
    sample_edge = pol ? pins.clk_fall : pins.clk_rise;
    ev = 3'h0;
    clr = 3'h0;
    done = 1'b0;
    q_nxt = q_r;
    q_nxt.rdata = 8'h00;

    // ****************************************
    // shift engine
    // ****************************************
    case (q_r.st)
      CSS_IDLE: begin
        q_nxt.sclk = ~pol;
        q_nxt.divcnt = 8'h00;
        if (te && !q_r.txempty && ctsok) begin // RULE4 RULE5 RULE6
          q_nxt.txsh = q_r.txbuf;
          q_nxt.txempty = 1'b1;
          q_nxt.bitcnt = 3'h0;
          q_nxt.txd = q_r.txbuf[0];
          ev[CSS_I_TX] = 1'b1;
          q_nxt.st = intclk ? CSS_LOW : CSS_HIGH;
          if (intclk) begin
            q_nxt.sclk = pol; // RULE5
          end
        end
      end
      CSS_LOW: begin
        // internal clock, first half period
        if (q_r.divcnt == q_r.div) begin
          q_nxt.divcnt = 8'h00;
          q_nxt.sclk = ~pol;
          q_nxt.rxsh = {pins.rx_lvl, q_r.rxsh[7:1]};
          q_nxt.st = CSS_HIGH;
          if (q_r.bitcnt == CSS_BITS) begin
            done = 1'b1;
          end
        end else begin
          q_nxt.divcnt = q_r.divcnt + 8'h01;
        end
      end
      CSS_HIGH: begin
        if (intclk) begin
          if (q_r.divcnt == q_r.div) begin
            q_nxt.divcnt = 8'h00;
            if (q_r.bitcnt == CSS_BITS) begin
              q_nxt.st = CSS_IDLE;
            end else begin
              q_nxt.sclk = pol;
              q_nxt.bitcnt = q_r.bitcnt + 3'h1;
              q_nxt.txsh = {1'b0, q_r.txsh[7:1]};
              q_nxt.txd = q_r.txsh[1];
              q_nxt.st = CSS_LOW;
            end
          end else begin
            q_nxt.divcnt = q_r.divcnt + 8'h01;
          end
        end else begin
          // partner supplies the clock
          if (sample_edge) begin // RULE6
            q_nxt.rxsh = {pins.rx_lvl, q_r.rxsh[7:1]};
            if (q_r.bitcnt == CSS_BITS) begin
              done = 1'b1;
              q_nxt.st = CSS_IDLE;
            end else begin
              q_nxt.bitcnt = q_r.bitcnt + 3'h1;
              q_nxt.txsh = {1'b0, q_r.txsh[7:1]}; // RULE4
              q_nxt.txd = q_r.txsh[1];
            end
          end
        end
      end
      default: begin
        q_nxt.st = CSS_IDLE;
      end
    endcase

    // ****************************************
    // receive completion
    // ****************************************
    if (done && re) begin
      q_nxt.rxbuf = q_nxt.rxsh; // RULE7
      if (q_r.rxfull) begin
        q_nxt.ovr = 1'b1; // RULE7
        ev[CSS_I_OVR] = 1'b1; // RULE8
      end else begin
        ev[CSS_I_RX] = 1'b1;
      end
      q_nxt.rxfull = 1'b1;
    end

    // ****************************************
    // flow control output
    // ****************************************
    if (!re || intclk) begin
      q_nxt.rts_n = 1'b1; // RULE2
    end else if (q_r.st == CSS_IDLE && q_nxt.st != CSS_IDLE) begin
      q_nxt.rts_n = 1'b1; // RULE1
    end else if (done || (q_r.st == CSS_IDLE && !q_r.ctrl[CSS_C_RE])) begin
      q_nxt.rts_n = 1'b0; // RULE12
    end

    // ****************************************
    // register port
    // ****************************************
    if (wr) begin
      case (addr)
        CSS_A_CTRL: q_nxt.ctrl = wdata;
        CSS_A_TXBUF: begin
          q_nxt.txbuf = wdata;
          q_nxt.txempty = 1'b0;
        end
        CSS_A_STAT: begin
          if (wdata[CSS_S_OVR]) begin
            q_nxt.ovr = q_nxt.ovr & ev[CSS_I_OVR];
          end
        end
        CSS_A_IRQ: clr = wdata[2:0];
        CSS_A_MASK: q_nxt.mask = wdata[2:0];
        CSS_A_DIV: q_nxt.div = wdata;
        default: q_nxt.mask = q_nxt.mask;
      endcase
    end
    // a control write with receive enable set and internal clock clear drives request low at once while idle
    if (wr && addr == CSS_A_CTRL && wdata[CSS_C_RE] && !wdata[CSS_C_INTCLK]
        && q_r.st == CSS_IDLE) begin
      q_nxt.rts_n = 1'b0; // RULE11
    end
    if (rd) begin
      case (addr)
        CSS_A_CTRL: q_nxt.rdata = q_r.ctrl;
        CSS_A_TXBUF: q_nxt.rdata = q_r.txbuf;
        CSS_A_RXBUF: begin
          q_nxt.rdata = q_r.rxbuf;
          q_nxt.rxfull = done & re;
        end
        CSS_A_STAT: q_nxt.rdata = {4'h0, q_r.st != CSS_IDLE, q_r.ovr, q_r.rxfull, q_r.txempty};
        CSS_A_IRQ: q_nxt.rdata = {5'h00, q_r.irqst};
        CSS_A_MASK: q_nxt.rdata = {5'h00, q_r.mask};
        CSS_A_DIV: q_nxt.rdata = q_r.div;
        default: q_nxt.rdata = 8'h00;
      endcase
    end
    q_nxt.irqst = w1c(q_r.irqst, ev, clr);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '{ctrl: CSS_CTRL_RST, div: CSS_DIV_RST, txempty: 1'b1, st: CSS_IDLE,
               sclk: 1'b1, txd: 1'b1, rts_n: 1'b1, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata = q_r.rdata;
  assign shift_clock_pin_o = q_r.sclk;
  assign shift_clock_pin_oe_n = ~q_r.ctrl[CSS_C_INTCLK];
  assign serial_out_pin = q_r.txd; // RULE4
  assign rts_n = q_r.rts_n | ~q_r.ctrl[CSS_C_RTS] | q_r.ctrl[CSS_C_INTCLK]; // RULE1 RULE2
  assign irq = |(q_r.irqst & q_r.mask);
endmodule : css_serial_channel
`default_nettype wire

// file: core/css_pkg.sv
// package: constants and types for the clock-synchronous serial channel
package css_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] CSS_A_CTRL = 4'h0;
  localparam logic [3:0] CSS_A_TXBUF = 4'h1;
  localparam logic [3:0] CSS_A_RXBUF = 4'h2;
  localparam logic [3:0] CSS_A_STAT = 4'h3;
  localparam logic [3:0] CSS_A_IRQ = 4'h4;
  localparam logic [3:0] CSS_A_MASK = 4'h5;
  localparam logic [3:0] CSS_A_DIV = 4'h6;
  // ctrl fields
  localparam int CSS_C_TE = 0;
  localparam int CSS_C_RE = 1;
  localparam int CSS_C_INTCLK = 2;
  localparam int CSS_C_POL = 3;
  localparam int CSS_C_RTS = 4;
  localparam int CSS_C_CTS = 5;
  // status fields
  localparam int CSS_S_TXEMPTY = 0;
  localparam int CSS_S_RXFULL = 1;
  localparam int CSS_S_OVR = 2;
  localparam int CSS_S_BUSY = 3;
  // irq fields
  localparam int CSS_I_RX = 0;
  localparam int CSS_I_TX = 1;
  localparam int CSS_I_OVR = 2;
  localparam logic [7:0] CSS_CTRL_RST = 8'h00;
  localparam logic [7:0] CSS_DIV_RST = 8'h04;
  localparam logic [2:0] CSS_BITS = 3'h7;
  // ****************************************
  // shift engine states
  // ****************************************
  typedef enum logic [2:0] {
    CSS_IDLE = 3'b001,
    CSS_LOW = 3'b010,
    CSS_HIGH = 3'b100
  } css_st_e;
endpackage : css_pkg

// file: core/css_pin_if.sv
// interface: synchronised pin levels and the edges of the shift clock
`timescale 1ns/1ns
`default_nettype none
interface css_pin_if;
  logic clk_lvl;
  logic clk_rise;
  logic clk_fall;
  logic cts_n_lvl;
  logic rx_lvl;
  modport sync (output clk_lvl, clk_rise, clk_fall, cts_n_lvl, rx_lvl);
  modport core (input clk_lvl, clk_rise, clk_fall, cts_n_lvl, rx_lvl);
endinterface : css_pin_if
`default_nettype wire

// file: core/css_sync.sv
// synchroniser: three flops per outside input, change counts when stages 2 and 3 agree
`timescale 1ns/1ns
`default_nettype none
module css_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // raw pins
  input wire logic shift_clock_in,
  input wire logic cts_n_in,
  input wire logic rx_in,
  // synchronised
  css_pin_if.sync p
);
  import css_pkg::*;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
    logic rise;
    logic fall;
  } css_sync_s;
  css_sync_s q_r, q_nxt;
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = {rx_in, cts_n_in, shift_clock_in};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    q_nxt.rise = 1'b0;
    q_nxt.fall = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (q_r.s2[i] == q_r.s3[i]) begin
        q_nxt.lvl[i] = q_r.s3[i];
      end
    end
    if (q_r.s2[0] == q_r.s3[0] && q_r.s3[0] != q_r.lvl[0]) begin
      q_nxt.rise = q_r.s3[0];
      q_nxt.fall = ~q_r.s3[0];
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '{s1: 3'h3, s2: 3'h3, s3: 3'h3, lvl: 3'h3, rise: 1'b0, fall: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end
  assign p.clk_lvl = q_r.lvl[0];
  assign p.cts_n_lvl = q_r.lvl[1];
  assign p.rx_lvl = q_r.lvl[2];
  assign p.clk_rise = q_r.rise;
  assign p.clk_fall = q_r.fall;
endmodule : css_sync
`default_nettype wire

// file: tb/css_serial_channel_checker.sv
// checker: port-level properties of the serial channel
`timescale 1ns/1ns
`default_nettype none
module css_serial_channel_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // pins
  input wire logic shift_clock_pin_i,
  input wire logic shift_clock_pin_o,
  input wire logic shift_clock_pin_oe_n,
  input wire logic serial_out_pin,
  input wire logic serial_in_pin,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic irq
);
  import css_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  rst_values_a: assert property ($fell(reset) |-> rts_n && serial_out_pin && shift_clock_pin_oe_n && !irq)
    else $error("outputs not idle after reset");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data outside read cycle");
  rts_internal_a: assert property (
    !shift_clock_pin_oe_n |-> rts_n) else $error("request low with internal clock");
  rts_ready_a: assert property (
    wr && addr == CSS_A_CTRL && wdata[CSS_C_RE] && wdata[CSS_C_RTS] && !wdata[CSS_C_INTCLK] |-> ##[1:2] !rts_n)
    else $error("request not low after receive enable");
  rts_start_a: assert property (
    wr && addr == CSS_A_TXBUF && shift_clock_pin_oe_n && !rts_n |-> ##[1:3] rts_n)
    else $error("request not high at word start");
  clk_start_a: assert property (
    wr && addr == CSS_A_TXBUF && !shift_clock_pin_oe_n |-> ##[1:3] !shift_clock_pin_o)
    else $error("internal clock not started");
  clk_half_a: assert property (
    !shift_clock_pin_oe_n && $fell(shift_clock_pin_o) |=> !shift_clock_pin_o [*4] ##1 shift_clock_pin_o)
    else $error("clock low half not five cycles");
  irq_mask_a: assert property (wr && addr == CSS_A_MASK && wdata == 8'h00 |-> ##2 !irq)
    else $error("interrupt high with all masked");
endmodule : css_serial_channel_checker
bind css_serial_channel css_serial_channel_checker chk_u (.clk(clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .shift_clock_pin_i(shift_clock_pin_i),
  .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe_n(shift_clock_pin_oe_n),
  .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
`default_nettype wire

// file: tb/css_far_end.sv
// far-end model: clock-synchronous peer that may supply the shift clock
`timescale 1ns/1ns
`default_nettype none
module css_far_end (
  // link
  input wire logic clk_wire,
  input wire logic data_from_dev,
  output logic ext_clk,
  output logic data_to_dev,
  // test control
  input wire logic run,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [2:0] idx = 3'h0;
  initial begin
    ext_clk = 1'b1;
    data_to_dev = 1'b1;
    rx_byte = 8'h00;
  end
  // clock stands high between frames, eight pulses per frame
  always @(posedge run) begin
    #7;
    repeat (8) begin
      ext_clk = 1'b0;
      #80;
      ext_clk = 1'b1;
      #80;
    end
  end
  always @(negedge clk_wire) begin
    data_to_dev = tx_byte[idx];
    idx = idx + 3'h1;
  end
  // after the last bit the line is held past the synchroniser, then flips
  always @(posedge clk_wire) begin
    rx_byte = {data_from_dev, rx_byte[7:1]};
    if (idx == 3'h0)
      data_to_dev <= #120 ~data_to_dev;
  end
endmodule : css_far_end
`default_nettype wire

// file: tb/css_serial_channel_bench.sv
// testbench: scenario tasks for the serial channel
`timescale 1ns/1ns
`default_nettype none
module css_serial_channel_bench;
  import css_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cts_n = 1'b1;
  logic run = 1'b0;
  logic [7:0] far_tx = 8'h00;
  logic [7:0] far_rx;
  logic [7:0] rdata;
  logic ck_o, ck_oe_n, ck_ext, sd_out, sd_in, rts_n, irq;
  wire ck_wire = ck_oe_n ? ck_ext : ck_o;
  int mismatches = 0;
  int samples_checked = 0;
  always #10 clk = ~clk;
  css_serial_channel DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .shift_clock_pin_i(ck_wire), .shift_clock_pin_o(ck_o), .shift_clock_pin_oe_n(ck_oe_n),
    .serial_out_pin(sd_out), .serial_in_pin(sd_in), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
  css_far_end far (.clk_wire(ck_wire), .data_from_dev(sd_out), .ext_clk(ck_ext), .data_to_dev(sd_in),
    .run(run), .tx_byte(far_tx), .rx_byte(far_rx));
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(d & m, exp);
  endtask : rd_chk
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // one frame of eight external clocks, then time for the synchroniser
  task clocks;
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    repeat (90) @(posedge clk);
    #1;
  endtask : clocks
  task t_reset;
    rd_chk(CSS_A_CTRL, 8'hFF, CSS_CTRL_RST);
    rd_chk(CSS_A_DIV, 8'hFF, CSS_DIV_RST);
    wr_reg(4'hF, 8'hFF);
    rd_chk(4'hF, 8'hFF, 8'h00);
    rd_chk(CSS_A_STAT, 8'h0F, 8'h01);
  endtask : t_reset
  task t_internal;
    logic [7:0] d;
    far_tx <= 8'hA5;
    wr_reg(CSS_A_MASK, 8'h01);
    wr_reg(CSS_A_CTRL, 8'h17);
    settle;
    chk({7'h00, rts_n}, 8'h01);
    chk({7'h00, ck_o}, 8'h01);
    wr_reg(CSS_A_TXBUF, 8'h3C);
    d = 8'h00;
    for (int i = 0; i < 200 && d[CSS_S_RXFULL] !== 1'b1; i++)
      rd_reg(CSS_A_STAT, d);
    settle;
    chk(far_rx, 8'h3C);
    chk({7'h00, irq}, 8'h01);
    rd_chk(CSS_A_RXBUF, 8'hFF, 8'hA5);
    wr_reg(CSS_A_IRQ, 8'h01);
    settle;
    chk({7'h00, irq}, 8'h00);
    wr_reg(CSS_A_MASK, 8'h00);
  endtask : t_internal
  task t_external;
    far_tx <= 8'h5A;
    wr_reg(CSS_A_CTRL, 8'h12);
    settle;
    chk({7'h00, rts_n}, 8'h00);
    clocks;
    rd_chk(CSS_A_STAT, 8'h02, 8'h00);
    wr_reg(CSS_A_CTRL, 8'h13);
    wr_reg(CSS_A_TXBUF, 8'hC3);
    cts_n <= 1'b0;
    settle;
    chk({7'h00, rts_n}, 8'h01);
    clocks;
    chk({7'h00, rts_n}, 8'h00);
    chk(far_rx, 8'hC3);
    rd_chk(CSS_A_RXBUF, 8'hFF, 8'h5A);
  endtask : t_external
  task t_overrun;
    wr_reg(CSS_A_IRQ, 8'hFF);
    far_tx <= 8'h81;
    wr_reg(CSS_A_TXBUF, 8'h00);
    clocks;
    wr_reg(CSS_A_IRQ, 8'h01);
    far_tx <= 8'h7E;
    wr_reg(CSS_A_TXBUF, 8'h00);
    clocks;
    chk({7'h00, rts_n}, 8'h00);
    rd_chk(CSS_A_STAT, 8'h06, 8'h06);
    rd_chk(CSS_A_IRQ, 8'h05, 8'h04);
    rd_chk(CSS_A_RXBUF, 8'hFF, 8'h7E);
  endtask : t_overrun
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_internal;
    t_external;
    t_overrun;
    stop_test;
  end
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule : css_serial_channel_bench
`default_nettype wire
